// ===== pwr_out_pkg.sv
// Purpose: shared constants for the battery power and output control block
// Assumes: 40 MHz clock
// Notes: output index order is charging, end discharge, backup low, dc valid, gauge, fault
package pwr_out_pkg;
	localparam int NUM_OUT = 6;
	localparam int NUM_PINS = 7;
	localparam logic [5:0] MASK_RESET = 6'h00;
	localparam logic [6:0] DRIVE_RESET = 7'h00;
	localparam int IDX_CHG = 0;
	localparam int IDX_EDV = 1;
	localparam int IDX_BCL = 2;
	localparam int IDX_DCV = 3;
	localparam int IDX_GGN = 4;
	localparam int IDX_SBF = 5;
	localparam int IDX_AUX = 6;
	localparam int SW_FILTER_NS = 1000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int SW_FILTER_CYC = (SW_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [5:0] SW_CNT_RESET = 6'h00;
	typedef enum logic [1:0] {
		CHG_IDLE,
		CHG_ARMED,
		CHG_ACTIVE
	} charge_state_type;
endpackage

// ===== sync2.sv
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: async low reset, value at reset given by parameter
// Notes: first stage read only by second stage
`timescale 1ns/1ps
module sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= INIT;
			q <= INIT;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// ===== battery_power_output_control.sv
// Purpose: system power switching, charge gating, backup status and annunciator outputs
// Assumes: single 40 MHz clock, host controls as plain ports, command pulses one cycle
// Notes: charge timing and termination arithmetic live outside; only their end event enters here
//
// What this block does
// - commanded charge waits for a charge command, starts only with dc valid high
// - charge command ignored while system power bit is low
// - commanded charge ends like dc-initiated one, and on abort command
// - abort command clears battery removed bit
// - power-off command clears system power bit; then a dc valid rising edge starts charging
// - power on means host-commanded charge; power off means dc-initiated charge
// - backup cell low bit follows the below-threshold comparator input
// - switch press with power off sets power, enables supply, stops charge, interrupts
// - switch press with power on only raises interrupt and flag
// - supply enable stays asserted while system power bit is one
// - seven open-drain outputs, six selectable host or status source
// - mask bit one makes output follow its status bit always
// - mask bit zero drives output from output drive register bit
// - in system-off, status outputs follow, host outputs hold last value
// - host writes to drive register change host outputs while powered
// - status word reports each status-driven annunciator state
// - charge ends, gauge invalid set, on dc loss, removal, fault, power change
// - charging only with dc valid high and charge enable written one
`timescale 1ns/1ps
module battery_power_output_control (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pwrSwitch_n,
	input wire logic dcValidIn,
	input wire logic backupBelowIn,
	input wire logic batteryRemovedIn,
	input wire logic batteryFaultIn,
	input wire logic endDischargeIn,
	input wire logic gaugeThresholdIn,
	input wire logic fullChargeDone,
	input wire logic chargeEnable,
	input wire logic chargeCmd,
	input wire logic abortCmd,
	input wire logic powerOffCmd,
	input wire logic irqClear,
	input wire logic driveWrite,
	input wire logic [6:0] driveData,
	input wire logic [5:0] sourceMask,
	output logic systemPower,
	output logic supplyEnable_n,
	output logic irq_n,
	output logic irqFlag,
	output logic chargingFlag,
	output logic batteryRemoved,
	output logic gaugeInvalid,
	output logic backupCellLow,
	output logic [5:0] statusWord,
	output logic [6:0] pinOut,
	output logic [6:0] pinOe_n
);
	// ----------------------------------------
	// reset and input synchronisers
	// ----------------------------------------
	logic rstMeta_r;
	logic rstSync_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_r <= 1'b0;
			rstSync_r <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSync_r <= rstMeta_r;
		end
	end
	logic [6:0] pinsSync;
	sync2 #(.W(7), .INIT(7'h01)) inSync (
		.clk(clk),
		.rst_n(rstSync_r),
		.d({gaugeThresholdIn, endDischargeIn, batteryFaultIn, batteryRemovedIn, backupBelowIn, dcValidIn,
			pwrSwitch_n}),
		.q(pinsSync)
	);
	logic swLevel_n;
	logic dcValid;
	logic bcBelow;
	logic remIn;
	logic faultIn;
	logic edvIn;
	logic ggnIn;
	assign swLevel_n = pinsSync[0];
	assign dcValid = pinsSync[1];
	assign bcBelow = pinsSync[2];
	assign remIn = pinsSync[3];
	assign faultIn = pinsSync[4];
	assign edvIn = pinsSync[5];
	assign ggnIn = pinsSync[6];

	// ----------------------------------------
	// shared decode
	// ----------------------------------------
	function automatic logic swAtEnd(input logic [5:0] cnt);
		swAtEnd = (cnt == 6'(pwr_out_pkg::SW_FILTER_CYC - 1));
	endfunction
	function automatic logic isActive(input pwr_out_pkg::charge_state_type st);
		isActive = (st == pwr_out_pkg::CHG_ACTIVE);
	endfunction

	// ----------------------------------------
	// power switch filter
	// ----------------------------------------
	// a press is a low level held for the filter time; bounce cannot toggle power twice
	logic [5:0] swCnt_r;
	logic swDone_r;
	logic press;
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			swCnt_r <= pwr_out_pkg::SW_CNT_RESET;
			swDone_r <= 1'b0;
		end else if (swLevel_n) begin
			swCnt_r <= pwr_out_pkg::SW_CNT_RESET;
			swDone_r <= 1'b0;
		end else if (!swDone_r) begin
			if (swAtEnd(swCnt_r)) begin
				swDone_r <= 1'b1;
			end else begin
				swCnt_r <= swCnt_r + 6'h01;
			end
		end
	end
	assign press = !swLevel_n && !swDone_r && swAtEnd(swCnt_r);

	// ----------------------------------------
	// system power and interrupt
	// ----------------------------------------
	logic powerChange;
	assign powerChange = (press && !systemPower) || (powerOffCmd && systemPower);
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			systemPower <= 1'b0;
		end else if (press && !systemPower) begin
			systemPower <= 1'b1;
		end else if (powerOffCmd) begin
			systemPower <= 1'b0;
		end
	end
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			supplyEnable_n <= 1'b1;
		end else begin
			supplyEnable_n <= !((press && !systemPower) || (systemPower && !powerOffCmd));
		end
	end
	// set wins over a same-cycle clear
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			irqFlag <= 1'b0;
			irq_n <= 1'b1;
		end else if (press) begin
			irqFlag <= 1'b1;
			irq_n <= 1'b0;
		end else if (irqClear) begin
			irqFlag <= 1'b0;
			irq_n <= 1'b1;
		end
	end

	// ----------------------------------------
	// charge action control
	// ----------------------------------------
	pwr_out_pkg::charge_state_type chgState_r;
	pwr_out_pkg::charge_state_type chgState_nxt;
	logic endFault;
	logic startOk;
	logic dcValidPrev_r;
	assign endFault = !dcValid || remIn || faultIn || powerChange;
	assign startOk = dcValid && chargeEnable && !remIn && !faultIn;
	always_comb begin
		chgState_nxt = chgState_r;
		case (chgState_r)
			pwr_out_pkg::CHG_IDLE: begin
				if (systemPower && chargeCmd && !powerChange) begin
					chgState_nxt = pwr_out_pkg::CHG_ARMED;
				end else if (!systemPower && !powerChange && startOk && !dcValidPrev_r) begin
					chgState_nxt = pwr_out_pkg::CHG_ACTIVE;
				end
			end
			pwr_out_pkg::CHG_ARMED: begin
				if (abortCmd || powerChange || remIn || faultIn) begin
					chgState_nxt = pwr_out_pkg::CHG_IDLE;
				end else if (startOk) begin
					chgState_nxt = pwr_out_pkg::CHG_ACTIVE;
				end
			end
			pwr_out_pkg::CHG_ACTIVE: begin
				if (endFault || abortCmd || fullChargeDone || !chargeEnable) begin
					chgState_nxt = pwr_out_pkg::CHG_IDLE;
				end
			end
			default: chgState_nxt = pwr_out_pkg::CHG_IDLE;
		endcase
	end
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			dcValidPrev_r <= 1'b0;
		end else begin
			dcValidPrev_r <= dcValid;
		end
	end
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			chgState_r <= pwr_out_pkg::CHG_IDLE;
		end else begin
			chgState_r <= chgState_nxt;
		end
	end
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			chargingFlag <= 1'b0;
		end else begin
			chargingFlag <= isActive(chgState_nxt);
		end
	end
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			gaugeInvalid <= 1'b0;
		end else if (isActive(chgState_r) && endFault) begin
			gaugeInvalid <= 1'b1;
		end else if (isActive(chgState_r) && fullChargeDone) begin
			gaugeInvalid <= 1'b0;
		end
	end
	// removal is sticky; a fresh removal wins over an abort in the same cycle
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			batteryRemoved <= 1'b0;
		end else if (remIn) begin
			batteryRemoved <= 1'b1;
		end else if (abortCmd) begin
			batteryRemoved <= 1'b0;
		end
	end
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			backupCellLow <= 1'b0;
		end else begin
			backupCellLow <= bcBelow;
		end
	end

	// ----------------------------------------
	// annunciator and host outputs
	// ----------------------------------------
	logic [5:0] statusBits;
	logic [6:0] drive_r;
	logic [6:0] level;
	assign statusBits = {faultIn, ggnIn, dcValid, bcBelow, edvIn, isActive(chgState_nxt)};
	// writes taken whenever offered; off state simply sees none, so values hold
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			drive_r <= pwr_out_pkg::DRIVE_RESET;
		end else if (driveWrite) begin
			drive_r <= driveData;
		end
	end
	always_comb begin
		level[pwr_out_pkg::IDX_AUX] = drive_r[pwr_out_pkg::IDX_AUX];
		for (int i = 0; i < pwr_out_pkg::NUM_OUT; i++) begin
			level[i] = sourceMask[i] ? statusBits[i] : drive_r[i];
		end
	end
	// open drain: oe low pulls pin low, high releases it
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			pinOut <= 7'h00;
			pinOe_n <= 7'h7f;
			statusWord <= 6'h00;
		end else begin
			pinOut <= 7'h00;
			pinOe_n <= ~level;
			statusWord <= statusBits;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	supply_follows_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		supplyEnable_n == !systemPower) else $error("supply enable not matching power bit");
	press_on_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		(press && !systemPower) |=> (systemPower && irqFlag && !irq_n && !chargingFlag))
		else $error("press from off did not power up");
	press_irq_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		(press && systemPower && !powerOffCmd) |=> (systemPower && irqFlag && !irq_n))
		else $error("press while on did not interrupt");
	flag_hold_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		(irqFlag && !irqClear) |=> irqFlag) else $error("interrupt flag dropped");
	off_cmd_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		(powerOffCmd && !(press && !systemPower)) |=> !systemPower) else $error("power off ignored");
	ignore_cmd_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		(!systemPower && chgState_r == pwr_out_pkg::CHG_IDLE && !dcValid) |=> !chargingFlag)
		else $error("charge started while off without dc");
	abort_ends_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		(abortCmd && chgState_r != pwr_out_pkg::CHG_IDLE) |=> !chargingFlag) else $error("abort not honoured");
	abort_clear_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		(abortCmd && !remIn) |=> !batteryRemoved) else $error("removed bit not cleared");
	charge_gate_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		chargingFlag |-> $past(dcValid) && $past(chargeEnable)) else $error("charging without dc or enable");
	dc_loss_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		(chgState_r == pwr_out_pkg::CHG_ACTIVE && !dcValid) |=> (gaugeInvalid && !chargingFlag))
		else $error("dc loss did not end charge");
	pin_source_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		sourceMask[pwr_out_pkg::IDX_DCV] |=> pinOe_n[pwr_out_pkg::IDX_DCV] == !$past(dcValid))
		else $error("status output wrong");
	backup_low_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		bcBelow |=> backupCellLow) else $error("backup low not set");
	cmd_ignored_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		(!systemPower && chargeCmd && chgState_r == pwr_out_pkg::CHG_IDLE) |=> chgState_r != pwr_out_pkg::CHG_ARMED)
		else $error("charge command taken while off");
	cmd_only_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		(systemPower && !chargeCmd && chgState_r == pwr_out_pkg::CHG_IDLE) |=> !chargingFlag)
		else $error("charge started while on without command");
	armed_wait_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		(chgState_r == pwr_out_pkg::CHG_ARMED && !dcValid) |=> !chargingFlag)
		else $error("armed charge started without dc");
	remove_ends_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		(isActive(chgState_r) && remIn) |=> (gaugeInvalid && !chargingFlag))
		else $error("removal did not end charge");
	fault_ends_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		(isActive(chgState_r) && faultIn) |=> (gaugeInvalid && !chargingFlag))
		else $error("fault did not end charge");
	off_ends_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		(isActive(chgState_r) && systemPower && powerOffCmd) |=> (gaugeInvalid && !chargingFlag))
		else $error("power change did not end charge");
	host_pin_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		!sourceMask[pwr_out_pkg::IDX_EDV] |=> pinOe_n[pwr_out_pkg::IDX_EDV] == !$past(drive_r[pwr_out_pkg::IDX_EDV]))
		else $error("host output wrong");
	aux_pin_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		1'b1 |=> pinOe_n[pwr_out_pkg::IDX_AUX] == !$past(drive_r[pwr_out_pkg::IDX_AUX]))
		else $error("aux output wrong");
	drive_hold_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		!driveWrite |=> drive_r == $past(drive_r))
		else $error("drive register changed without write");
	dc_status_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		1'b1 |=> statusWord[pwr_out_pkg::IDX_DCV] == $past(dcValid))
		else $error("status word dc bit wrong");
	backup_clear_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		!bcBelow |=> !backupCellLow)
		else $error("backup low not cleared");
	cmd_charge_c: cover property (@(posedge clk) disable iff (!rstSync_r)
		chgState_r == pwr_out_pkg::CHG_ARMED ##[1:20] chargingFlag);
	power_up_c: cover property (@(posedge clk) disable iff (!rstSync_r) press && !systemPower);
	dc_charge_c: cover property (@(posedge clk) disable iff (!rstSync_r) !systemPower && chargingFlag);
	remove_c: cover property (@(posedge clk) disable iff (!rstSync_r) batteryRemoved && abortCmd);
endmodule

// ===== switch_model.sv
// Purpose: model of the external power switch with its pull-up
// Assumes: press request is a one-cycle pulse from the bench
// Notes: holds the pin low longer than the design's press filter
`timescale 1ns/1ps
module switch_model #(
	parameter int HOLD = 60
) (
	input wire logic clk,
	input wire logic pressReq,
	output logic pwrSwitch_n
);
	// ----------------------------------------
	// contact hold
	// ----------------------------------------
	int holdCnt = 0;
	always_ff @(posedge clk) begin
		if (pressReq)
			holdCnt <= HOLD;
		else if (holdCnt > 0)
			holdCnt <= holdCnt - 1;
	end
	// released contact goes to the pull-up level
	assign pwrSwitch_n = !(holdCnt > 0);
endmodule

// ===== tb.sv
// Purpose: self-checking bench for the power and output control block
// Assumes: 40 MHz clock, host pulses one cycle wide
// Notes: fault, discharge and gauge inputs stay tied low
`timescale 1ns/1ps
module tb;
	logic clk = 0, rst_n = 0, pressReq = 0, pwrSwitch_n;
	logic dcValidIn = 0, backupBelowIn = 0, chargeEnable = 0, remPin = 0;
	logic chargeCmd = 0, abortCmd = 0, powerOffCmd = 0, irqClear = 0, driveWrite = 0;
	logic [6:0] driveData = 7'h00;
	logic [5:0] sourceMask = 6'h00;
	logic systemPower, supplyEnable_n, irq_n, irqFlag, chargingFlag;
	logic batteryRemoved, gaugeInvalid, backupCellLow;
	logic [5:0] statusWord;
	logic [6:0] pinOut, pinOe_n;
	int n_mismatch = 0, comparisons = 0;
	always #12.5 clk = ~clk;
	switch_model i_switch (.clk(clk), .pressReq(pressReq), .pwrSwitch_n(pwrSwitch_n));
	battery_power_output_control i_dut (.clk(clk), .rst_n(rst_n), .pwrSwitch_n(pwrSwitch_n),
		.dcValidIn(dcValidIn), .backupBelowIn(backupBelowIn), .batteryRemovedIn(remPin),
		.batteryFaultIn(1'b0), .endDischargeIn(1'b0), .gaugeThresholdIn(1'b0),
		.fullChargeDone(1'b0), .chargeEnable(chargeEnable), .chargeCmd(chargeCmd),
		.abortCmd(abortCmd), .powerOffCmd(powerOffCmd), .irqClear(irqClear),
		.driveWrite(driveWrite), .driveData(driveData), .sourceMask(sourceMask),
		.systemPower(systemPower), .supplyEnable_n(supplyEnable_n), .irq_n(irq_n),
		.irqFlag(irqFlag), .chargingFlag(chargingFlag), .batteryRemoved(batteryRemoved),
		.gaugeInvalid(gaugeInvalid), .backupCellLow(backupCellLow),
		.statusWord(statusWord), .pinOut(pinOut), .pinOe_n(pinOe_n));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [6:0] seen, input logic [6:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic pick(input int k);
		case (k)
			0: pick = irqFlag;
			1: pick = chargingFlag;
			default: pick = pinOe_n[2];
		endcase
	endfunction
	// bounded wait, long enough for the press filter plus sync
	task automatic waitFor(input int k, input logic v);
		for (int i = 0; i < 100; i++) begin
			if (pick(k) === v)
				return;
			@(posedge clk);
			#1;
		end
		n_mismatch++;
		$display("CHECK FAILED t=%0t wait expired", $time);
		report_and_stop();
	endtask
	task automatic pulse(input int k);
		@(posedge clk);
		case (k)
			0: chargeCmd <= 1;
			1: abortCmd <= 1;
			2: powerOffCmd <= 1;
			3: irqClear <= 1;
			4: driveWrite <= 1;
			default: pressReq <= 1;
		endcase
		@(posedge clk);
		{chargeCmd, abortCmd, powerOffCmd, irqClear, driveWrite, pressReq} <= 6'h00;
		@(posedge clk);
		#1;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic tOff();
		chk(pinOe_n, 7'h7f);
		chk({supplyEnable_n, irq_n, systemPower}, 7'h06);
		pulse(0);
		settle(4);
		chk(chargingFlag, 1'b0);
		$display("test off done");
	endtask
	task automatic tPress();
		pulse(5);
		waitFor(0, 1'b1);
		chk({systemPower, supplyEnable_n, irq_n}, 7'h04);
		settle(3);
		chk(irqFlag, 1'b1);
		pulse(3);
		chk({irqFlag, irq_n}, 7'h01);
		$display("test press done");
	endtask
	task automatic tCharge();
		// slope enable sits outside; charge current stays steady here
		chargeEnable <= 1;
		pulse(0);
		settle(5);
		chk(chargingFlag, 1'b0);
		dcValidIn <= 1;
		waitFor(1, 1'b1);
		chk(statusWord[0], 1'b1);
		pulse(1);
		chk({chargingFlag, batteryRemoved}, 7'h00);
		settle(6);
		chk(chargingFlag, 1'b0);
		$display("test charge done");
	endtask
	task automatic tDcLoss();
		chk(gaugeInvalid, 1'b0);
		pulse(0);
		chk(chargingFlag, 1'b1);
		dcValidIn <= 0;
		waitFor(1, 1'b0);
		chk(gaugeInvalid, 1'b1);
		remPin <= 1;
		settle(4);
		chk(batteryRemoved, 1'b1);
		remPin <= 0;
		settle(3);
		pulse(1);
		chk(batteryRemoved, 1'b0);
		$display("test dc loss done");
	endtask
	task automatic tPressOn();
		pulse(5);
		waitFor(0, 1'b1);
		chk({systemPower, supplyEnable_n, irq_n}, 7'h04);
		pulse(3);
		$display("test press on done");
	endtask
	task automatic tPins();
		driveData <= 7'h2a;
		pulse(4);
		chk(pinOe_n, ~7'h2a);
		chk(pinOut, 7'h00);
		backupBelowIn <= 1;
		sourceMask <= 6'h04;
		waitFor(2, 1'b0);
		chk({backupCellLow, statusWord[2]}, 7'h03);
		$display("test pins done");
	endtask
	task automatic tPowerOff();
		driveData <= 7'h41;
		pulse(4);
		chk(pinOe_n, ~7'h45);
		if (chargingFlag)
			pulse(1);
		pulse(2);
		chk({systemPower, supplyEnable_n}, 7'h01);
		backupBelowIn <= 0;
		waitFor(2, 1'b1);
		chk(pinOe_n, ~7'h41);
		dcValidIn <= 1;
		waitFor(1, 1'b1);
		chk(statusWord[3], 1'b1);
		$display("test power off done");
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1;
		settle(6);
		tOff();
		tPress();
		tCharge();
		tDcLoss();
		tPressOn();
		tPins();
		tPowerOff();
		report_and_stop();
	end
endmodule
